// ---- common/uvc_pins_if.sv ----
// Purpose: pin group between the sequencer and the pin driver
// Assumes: one clock domain
// Notes: all signals active high inside; driver inverts select, gate and pulse
`timescale 1ns/1ps
interface uvc_pins_if;
   logic select;
   logic gate;
   logic pulse;
   logic high_supply;
   logic id_high;
   logic drive_data;
   logic [uvc_pkg::ADDR_W-1:0] addr;
   logic [uvc_pkg::DATA_W-1:0] wdata;
   modport seq (output select, gate, pulse, high_supply, id_high,
      drive_data, addr, wdata);
   modport drv (input select, gate, pulse, high_supply, id_high,
      drive_data, addr, wdata);
endinterface

// ---- common/uvc_pkg.sv ----
// Purpose: constants and types for the UV EPROM host controller
// Assumes: 10 MHz clock, 100 ns period
// Notes: times in ns, cycle counts derived from them
package uvc_pkg;
   localparam int CLK_NS = 100;
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;
   // Access times of the fastest grade
   localparam int ADDRESS_ACCESS_NS = 180;
   localparam int GATE_ACCESS_NS = 65;
   localparam int FLOAT_NS = 55;
   // Program pulse width
   localparam int PROG_PULSE_NS = 1000;
   // Least times round up
   localparam int ADDR_CYC = (ADDRESS_ACCESS_NS + CLK_NS - 1) / CLK_NS;
   localparam int GATE_CYC = (GATE_ACCESS_NS + CLK_NS - 1) / CLK_NS;
   localparam int SETUP_CYC =
      (ADDRESS_ACCESS_NS - GATE_ACCESS_NS + CLK_NS - 1) / CLK_NS;
   localparam int FLOAT_CYC = (FLOAT_NS + CLK_NS - 1) / CLK_NS;
   localparam int PULSE_CYC = (PROG_PULSE_NS + CLK_NS - 1) / CLK_NS;
   // Gated cycles beyond access: two synchroniser stages and one spare
   localparam int SYNC_MARGIN_CYC = 3;
   // Cycles held after the pulse before the answer
   localparam int RECOVER_CYC = 1;
   localparam int CNT_W = 8;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   // Host commands
   typedef enum logic [1:0] {
      UVC_CMD_READ,
      UVC_CMD_PROGRAM,
      UVC_CMD_VERIFY,
      UVC_CMD_IDCODE
   } uvc_cmd_e;
endpackage

// ---- design/uvc_host.sv ----
// Purpose: host controller driving a UV EPROM through its pins
// Assumes: one command at a time, fastest access grade, 10 MHz clock
// Notes: supply and high-voltage lines are logic requests to switches
//
// Summary of operation
// [RULE1] Data read only with both selects low
// [RULE2] Output gate only gates data out
// [RULE3] Select high gives standby, outputs float
// [RULE4] Address and select access delays equal
// [RULE5] Gate after address access minus gate
// [RULE6] Erased bits read one; program clears
// [RULE7] Program: high supply, select low, pulse
// [RULE8] Id code: high line nine, selects low
// [RULE9] Select per device, gate shared read
// [RULE10] Disable and inhibit float; verify reads
`timescale 1ns/1ps
module uvc_host (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Command port
   input wire logic cmd_valid,
   input wire uvc_pkg::uvc_cmd_e cmd,
   input wire logic [uvc_pkg::ADDR_W-1:0] cmd_addr,
   input wire logic [uvc_pkg::DATA_W-1:0] cmd_wdata,
   output logic cmd_ready,
   output logic rsp_valid,
   output logic [uvc_pkg::DATA_W-1:0] rsp_data,
   output logic rsp_mismatch,
   // Memory pins
   output logic chip_select_n,
   output logic output_gate_n,
   output logic program_n,
   output logic vpp_high,
   output logic id_select_high_voltage_line,
   output logic [uvc_pkg::ADDR_W-1:0] word_address,
   input wire logic [uvc_pkg::DATA_W-1:0] byte_data_pins_in,
   output logic [uvc_pkg::DATA_W-1:0] byte_data_pins_out,
   output logic byte_data_pins_oe
);
   typedef enum logic [2:0] {
      UVC_IDLE, UVC_SETUP, UVC_GATE, UVC_PULSE, UVC_RECOVER, UVC_FLOAT
   } uvc_state_e;

   uvc_state_e state;
   uvc_pkg::uvc_cmd_e op;
   logic [uvc_pkg::CNT_W-1:0] cnt;
   logic [uvc_pkg::DATA_W-1:0] sync1, sync2, wbyte;
   logic [uvc_pkg::ADDR_W-1:0] abuf;
   uvc_pins_if pins();

   // Reads, verify and id use the gated output phase
   function automatic logic is_read(input uvc_pkg::uvc_cmd_e c);
      return c != uvc_pkg::UVC_CMD_PROGRAM;
   endfunction

   // Program and verify run under the programming supply
   function automatic logic needs_vpp(input uvc_pkg::uvc_cmd_e c);
      return c == uvc_pkg::UVC_CMD_PROGRAM || c == uvc_pkg::UVC_CMD_VERIFY;
   endfunction

   // Data pins come from another device: two flops first
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= byte_data_pins_in;
         sync2 <= sync1;
      end
   end

   // Sequencer; pin registers add one cycle, counts cover it
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= UVC_IDLE;
         op <= uvc_pkg::UVC_CMD_READ;
         cnt <= '0;
         abuf <= '0;
         wbyte <= '0;
      end else begin
         case (state)
            UVC_IDLE: begin
               if (cmd_valid) begin
                  op <= cmd;
                  abuf <= cmd_addr;
                  wbyte <= cmd_wdata;
                  state <= UVC_SETUP;
                  // [RULE5] select before gate
                  cnt <= uvc_pkg::CNT_W'(uvc_pkg::SETUP_CYC);
               end
            end
            UVC_SETUP: begin
               if (cnt != '0) begin
                  cnt <= cnt - 1'b1;
               end else if (is_read(op)) begin
                  state <= UVC_GATE;
                  // [RULE4] wait gate access plus sync
                  cnt <= uvc_pkg::CNT_W'(uvc_pkg::GATE_CYC
                     + uvc_pkg::SYNC_MARGIN_CYC);
               end else begin
                  state <= UVC_PULSE;
                  cnt <= uvc_pkg::CNT_W'(uvc_pkg::PULSE_CYC - 1);
               end
            end
            UVC_GATE: begin
               if (cnt != '0) begin
                  cnt <= cnt - 1'b1;
               end else begin
                  state <= UVC_FLOAT;
                  cnt <= uvc_pkg::CNT_W'(uvc_pkg::FLOAT_CYC);
               end
            end
            UVC_PULSE: begin
               if (cnt != '0) begin
                  cnt <= cnt - 1'b1;
               end else begin
                  state <= UVC_RECOVER;
                  cnt <= uvc_pkg::CNT_W'(uvc_pkg::RECOVER_CYC);
               end
            end
            UVC_RECOVER: begin
               if (cnt != '0) begin
                  cnt <= cnt - 1'b1;
               end else begin
                  state <= UVC_FLOAT;
                  cnt <= uvc_pkg::CNT_W'(uvc_pkg::FLOAT_CYC);
               end
            end
            UVC_FLOAT: begin
               // Let the device release the bus before the next cycle
               if (cnt != '0) begin
                  cnt <= cnt - 1'b1;
               end else begin
                  state <= UVC_IDLE;
               end
            end
            default: state <= UVC_IDLE;
         endcase
      end
   end

   // Pin intents; the defaults leave the part in standby, bus released
   always_comb begin
      // [RULE3] standby when deselected
      pins.select = 1'b0;
      pins.gate = 1'b0;
      pins.pulse = 1'b0;
      pins.high_supply = 1'b0;
      pins.id_high = 1'b0;
      pins.drive_data = 1'b0;
      pins.addr = abuf;
      pins.wdata = wbyte;
      case (state)
         UVC_SETUP, UVC_RECOVER: begin
            // [RULE9] select only this device
            pins.select = 1'b1;
            // [RULE10] verify under high supply
            pins.high_supply = needs_vpp(op);
            // [RULE8] id readout with high line
            pins.id_high = op == uvc_pkg::UVC_CMD_IDCODE;
            // [RULE7] byte on pins
            pins.drive_data = op == uvc_pkg::UVC_CMD_PROGRAM;
         end
         UVC_GATE: begin
            pins.select = 1'b1;
            // [RULE1] [RULE2] gate only to read
            pins.gate = 1'b1;
            pins.high_supply = needs_vpp(op);
            pins.id_high = op == uvc_pkg::UVC_CMD_IDCODE;
         end
         UVC_PULSE: begin
            pins.select = 1'b1;
            // [RULE7] low program pulse
            pins.pulse = 1'b1;
            pins.high_supply = needs_vpp(op);
            pins.drive_data = op == uvc_pkg::UVC_CMD_PROGRAM;
         end
         UVC_FLOAT: begin
            // Line nine lags select by two cycles on the way out
            pins.id_high = op == uvc_pkg::UVC_CMD_IDCODE;
         end
         default: begin
            // Idle keeps every default
            pins.select = 1'b0;
         end
      endcase
   end

   uvc_pin_drv u_drv (
      .clk(clk),
      .rstn(rstn),
      .p(pins.drv),
      .chip_select_n(chip_select_n),
      .output_gate_n(output_gate_n),
      .program_n(program_n),
      .vpp_high(vpp_high),
      .id_select_high_voltage_line(id_select_high_voltage_line),
      .word_address(word_address),
      .data_out(byte_data_pins_out),
      .data_oe(byte_data_pins_oe)
   );

   // Ready hint; a command offered while idle is taken even if this is low
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cmd_ready <= 1'b0;
      end else begin
         cmd_ready <= state == UVC_IDLE && !cmd_valid;
      end
   end

   // Response on last gated or recovery cycle; verify compares stored vs intended
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rsp_valid <= 1'b0;
         rsp_data <= '0;
         rsp_mismatch <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         if (state == UVC_GATE && cnt == '0) begin
            rsp_valid <= 1'b1;
            rsp_data <= sync2;
            // [RULE6] verify expects exact byte
            rsp_mismatch <= op == uvc_pkg::UVC_CMD_VERIFY && sync2 != wbyte;
         end else if (state == UVC_RECOVER && cnt == '0) begin
            rsp_valid <= 1'b1;
            rsp_data <= wbyte;
            rsp_mismatch <= 1'b0;
         end
      end
   end
endmodule

// ---- design/uvc_pin_drv.sv ----
// Purpose: register every pin level going to the memory
// Assumes: sequencer gives active-high intents
// Notes: pins are flip-flop outputs; bus driven only with gate high
`timescale 1ns/1ps
module uvc_pin_drv (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Intents
   uvc_pins_if.drv p,
   // Pins
   output logic chip_select_n,
   output logic output_gate_n,
   output logic program_n,
   output logic vpp_high,
   output logic id_select_high_voltage_line,
   output logic [uvc_pkg::ADDR_W-1:0] word_address,
   output logic [uvc_pkg::DATA_W-1:0] data_out,
   output logic data_oe
);
   // Control pins idle deselected
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         chip_select_n <= 1'b1;
         output_gate_n <= 1'b1;
         program_n <= 1'b1;
         vpp_high <= 1'b0;
         id_select_high_voltage_line <= 1'b0;
      end else begin
         chip_select_n <= ~p.select;
         output_gate_n <= ~p.gate;
         program_n <= ~p.pulse;
         vpp_high <= p.high_supply;
         id_select_high_voltage_line <= p.id_high;
      end
   end

   // Address and write data; never drive while gate low to avoid fights
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         word_address <= '0;
         data_out <= '0;
         data_oe <= 1'b0;
      end else begin
         word_address <= p.addr;
         data_out <= p.wdata;
         data_oe <= p.drive_data & ~p.gate;
      end
   end
endmodule

// ---- dv/uvc_eprom_model.sv ----
// Purpose: behavioural memory at the far side of the host
// Assumes: pins as the host drives them, no pull on the data bus
// Notes: code values are arbitrary
`timescale 1ns/1ps
module uvc_eprom_model #(
   parameter logic [7:0] MAKER = 8'h5a, // Arbitrary value
   parameter logic [7:0] PART = 8'ha5 // Arbitrary value
) (
   // Control pins, active low selects
   input wire logic e_n,
   input wire logic g_n,
   input wire logic p_n,
   input wire logic vpp,
   input wire logic idv,
   // Address and bus
   input wire logic [12:0] a,
   input wire logic [7:0] d,
   output logic [7:0] q
);
   logic [7:0] mem [8192];
   logic [7:0] rd;
   logic [7:0] last = 8'h00;
   logic drv;
   logic drv_d;
   initial foreach (mem[i]) mem[i] = 8'hff;
   always @(negedge p_n) if (!e_n && g_n && vpp) mem[a] &= d;
   assign rd = idv ? (a[0] ? PART : MAKER) : mem[a];
   assign drv = !e_n && !g_n && p_n;
   // late after gate; stale bits shown inverted till then
   always @(drv) drv_d <= #65 drv;
   always @(drv or drv_d or rd) if (drv && drv_d) last = rd;
   assign q = (drv && drv_d) ? rd : ~last;
endmodule

// ---- dv/uvc_host_chk.sv ----
// Purpose: pin protocol checks on the host controller
// Assumes: one clock, asynchronous active-low reset
// Notes: cycle counts follow the sequencer's counters
`timescale 1ns/1ps
module uvc_host_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Handshake
   input wire logic cmd_ready,
   input wire logic rsp_valid,
   // Memory pins
   input wire logic chip_select_n,
   input wire logic output_gate_n,
   input wire logic program_n,
   input wire logic vpp_high,
   input wire logic id_select_high_voltage_line,
   input wire logic [uvc_pkg::ADDR_W-1:0] word_address,
   input wire logic byte_data_pins_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   a_gate_setup: assert property (
      $fell(output_gate_n) |-> $past(!chip_select_n, 2)
      && word_address == $past(word_address, 2))
      else $error("gate fell too early");
   a_read_hold: assert property (
      $fell(output_gate_n) |-> (!output_gate_n && !chip_select_n
      && !byte_data_pins_oe)[*5] ##0 rsp_valid)
      else $error("read window broken");
   a_pulse_setup: assert property (
      $fell(program_n) |-> !chip_select_n && output_gate_n
      && vpp_high && byte_data_pins_oe)
      else $error("pulse outside program mode");
   a_pulse_width: assert property (
      $fell(program_n) |-> !program_n[*8] ##1 !program_n[*2] ##1 program_n)
      else $error("pulse width wrong");
   a_prog_resp: assert property (
      $rose(program_n) |-> ##1 rsp_valid)
      else $error("no answer after pulse");
   a_rsp_pulse: assert property (
      rsp_valid |=> !rsp_valid[*2])
      else $error("response too long");
   a_idle_standby: assert property (
      cmd_ready |-> chip_select_n && output_gate_n && program_n
      && !vpp_high && !byte_data_pins_oe)
      else $error("idle pins not in standby");
   a_id_levels: assert property (
      id_select_high_voltage_line |-> !vpp_high && program_n)
      else $error("id line with program levels");
endmodule
bind uvc_host uvc_host_chk u_uvc_host_chk (
   .clk(clk), .rstn(rstn), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
   .chip_select_n(chip_select_n), .output_gate_n(output_gate_n),
   .program_n(program_n), .vpp_high(vpp_high),
   .id_select_high_voltage_line(id_select_high_voltage_line),
   .word_address(word_address), .byte_data_pins_oe(byte_data_pins_oe));

// ---- dv/uvc_host_tb_top.sv ----
// Purpose: self-checking bench for the host controller
// Assumes: model holds contents across host resets
// Notes: notes queued by the driver, checked by a monitor
`timescale 1ns/1ps
module uvc_host_tb_top;
   localparam logic [7:0] MAKER = 8'h5a; // Arbitrary value
   localparam logic [7:0] PART = 8'ha5; // Arbitrary value
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic cmd_valid = 1'b0;
   uvc_pkg::uvc_cmd_e cmd = uvc_pkg::UVC_CMD_READ;
   logic [12:0] cmd_addr = 13'h0000;
   logic [7:0] cmd_wdata = 8'h00;
   logic cmd_ready, rsp_valid, rsp_mismatch, chip_select_n, output_gate_n;
   logic program_n, vpp_high, id_select_high_voltage_line;
   logic byte_data_pins_oe;
   logic [7:0] rsp_data, byte_data_pins_out, byte_data_pins_in, q, w;
   logic [12:0] word_address, a;
   logic [8:0] exp_q [$];
   logic [8:0] got;
   logic [7:0] sh [8192];
   int n_fail = 0;
   int checked = 0;
   int cyc = 0;
   int seed = 32'h74d24baf;
   initial forever #50 clk = ~clk;
   // Wire level: host wins only while it drives
   assign byte_data_pins_in = byte_data_pins_oe ? byte_data_pins_out : q;
   uvc_host u_uvc_host (
      .clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd(cmd),
      .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .rsp_mismatch(rsp_mismatch), .chip_select_n(chip_select_n),
      .output_gate_n(output_gate_n), .program_n(program_n),
      .vpp_high(vpp_high),
      .id_select_high_voltage_line(id_select_high_voltage_line),
      .word_address(word_address), .byte_data_pins_in(byte_data_pins_in),
      .byte_data_pins_out(byte_data_pins_out),
      .byte_data_pins_oe(byte_data_pins_oe));
   uvc_eprom_model #(.MAKER(MAKER), .PART(PART)) u_uvc_eprom_model (
      .e_n(chip_select_n), .g_n(output_gate_n), .p_n(program_n),
      .vpp(vpp_high), .idv(id_select_high_voltage_line),
      .a(word_address), .d(byte_data_pins_in), .q(q));
   task automatic close_out();
      $display("compares %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic do_reset();
      rstn <= 1'b0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
   endtask
   // Valid held three edges: repeats while busy must be ignored
   task automatic run(input uvc_pkg::uvc_cmd_e c, input logic [12:0] ad,
      input logic [7:0] wd, input logic [7:0] e, input logic m);
      while (cmd_ready !== 1'b1) @(posedge clk);
      cmd <= c;
      cmd_addr <= ad;
      cmd_wdata <= wd;
      cmd_valid <= 1'b1;
      exp_q.push_back({m, e});
      repeat (3) @(posedge clk);
      cmd_valid <= 1'b0;
      @(posedge clk);
   endtask
   // Oldest note against each response; cycle ceiling cuts hangs
   // Sampled mid-cycle, away from the edge that launches the answer
   always @(negedge clk) begin
      cyc++;
      if (rsp_valid === 1'b1) begin
         checked++;
         got = {rsp_mismatch, rsp_data};
         if (exp_q.size() == 0 || got !== exp_q.pop_front()) begin
            n_fail++;
            $display("FAIL %0t response differs from note", $time);
         end
      end
      if (cyc == 8000) begin
         n_fail++;
         close_out();
      end
   end
   initial begin
      foreach (sh[i]) sh[i] = 8'hff;
      do_reset();
      for (int i = 0; i < 6; i++) begin
         a = (i == 0) ? 13'h0000 : (i == 1) ? 13'h1fff : 13'($random(seed));
         run(uvc_pkg::UVC_CMD_READ, a, 8'h00, sh[a], 1'b0);
         for (int k = 0; k < 2; k++) begin
            w = 8'($random(seed));
            sh[a] = sh[a] & w;
            run(uvc_pkg::UVC_CMD_PROGRAM, a, w, w, 1'b0);
         end
         run(uvc_pkg::UVC_CMD_READ, a, 8'h00, sh[a], 1'b0);
         run(uvc_pkg::UVC_CMD_VERIFY, a, sh[a], sh[a], 1'b0);
         run(uvc_pkg::UVC_CMD_VERIFY, a, ~sh[a], sh[a], 1'b1);
      end
      // Contents outlive a reset in mid-run, once the last answer is in
      while (exp_q.size() != 0) @(posedge clk);
      do_reset();
      run(uvc_pkg::UVC_CMD_IDCODE, 13'h0000, 8'h00, MAKER, 1'b0);
      run(uvc_pkg::UVC_CMD_IDCODE, 13'h0001, 8'h00, PART, 1'b0);
      run(uvc_pkg::UVC_CMD_READ, 13'h1fff, 8'h00, sh[13'h1fff], 1'b0);
      while (exp_q.size() != 0) @(posedge clk);
      close_out();
   end
endmodule
